/* File: rtl/drlm_line_monitor.sv */
// Ring detect conditioning and line voltage / loop current sense top
//
// What this block does
// - Rectifier select 0 gives half-wave, 1 gives full-wave ring rectification.
// - Rectification mode affects both ring detect pin and serial data stream.
// - Five-bit sense reports voltage, current or monitor per mode bits.
// - On-hook voltage: 2.75 V/bit, 00000 no line, 11111 maximum.
// - Force on-hook goes on-hook without restarting the off-hook counter.
// - Mode 0, on-hook, monitor on: all ones with voltage, else zeros.
// - Off-hook reports loop current, 3 mA/bit, 11111 meaning overload.
`timescale 1ns/1ps
`default_nettype none
module drlm_line_monitor
  import drlm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire drlm_ctrl_t  ctrl,
  input  wire drlm_meas_t  meas,
  input  wire logic [7:0]  ring_sense_inputs,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  output logic      [7:0]  reg_rdata_r,
  output logic             reg_rvalid_r,
  output logic             ring_detect_pin_r,
  output logic      [7:0]  serial_data_output_r,
  output logic             serial_data_valid_r,
  output logic             line_offhook_r,
  output logic [OFFHOOK_CNT_W-1:0] offhook_count_r
);

  logic [7:0]      rect;
  logic            ring_det;
  logic [4:0]      line_sense_value_r;
  logic [4:0]      line_sense_value_nxt;
  drlm_sense_src_t sense_src;
  drlm_sdo_src_t   sdo_src;
  logic            force_onhook;
  logic            offhook_nxt;
  logic            forced_onhook_r;

  function automatic drlm_sense_src_t sense_select(input drlm_ctrl_t c);
    if (c.mode) begin
      sense_select = DRLM_SRC_VOLTAGE;
    end else if (c.hook_off_request) begin
      sense_select = DRLM_SRC_CURRENT;
    end else if (c.onhook_monitor_enable) begin
      sense_select = DRLM_SRC_PRESENCE;
    end else begin
      sense_select = DRLM_SRC_ZERO;
    end
  endfunction

  drlm_ring_rect u_rect (
    .ref_clk           (ref_clk),
    .rst               (rst),
    .ring_sense_inputs (ring_sense_inputs),
    .full_wave         (ctrl.ring_rectifier_full_wave),
    .squelch           (ctrl.ring_squelch),
    .rect_r            (rect),
    .ring_det_r        (ring_det)
  );

  assign sense_src    = sense_select(ctrl);
  assign force_onhook = ctrl.mode && ctrl.hook_off_request;
  assign offhook_nxt  = ctrl.hook_off_request && !ctrl.mode;

  always_comb begin
    case (sense_src)
      DRLM_SRC_VOLTAGE:  line_sense_value_nxt = meas.line_voltage_code;
      DRLM_SRC_CURRENT:  line_sense_value_nxt = meas.loop_current_code;
      DRLM_SRC_PRESENCE: line_sense_value_nxt = meas.line_voltage_present ?
                           SENSE_ALL_ONES : SENSE_ALL_ZEROS;
      default:           line_sense_value_nxt = SENSE_ALL_ZEROS;
    endcase
  end

  // Codes pass through unscaled: the converter holds 2.75 V or 3 mA per step
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_sense_value_r <= SENSE_RESET;
    end else begin
      line_sense_value_r <= line_sense_value_nxt;
    end
  end

  always_comb begin
    if (!ctrl.hook_off_request && !ctrl.onhook_monitor_enable) begin
      sdo_src = DRLM_SDO_RING;
    end else if (force_onhook && !ctrl.onhook_monitor_enable) begin
      sdo_src = DRLM_SDO_NONE;
    end else begin
      sdo_src = DRLM_SDO_LINE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serial_data_output_r <= 8'h00;
      serial_data_valid_r  <= 1'b0;
    end else begin
      case (sdo_src)
        DRLM_SDO_RING: begin
          serial_data_output_r <= rect;
          serial_data_valid_r  <= 1'b1;
        end
        DRLM_SDO_LINE: begin
          serial_data_output_r <= meas.line_sample;
          serial_data_valid_r  <= 1'b1;
        end
        default: begin
          serial_data_output_r <= 8'h00;
          serial_data_valid_r  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ring_detect_pin_r <= 1'b0;
    end else begin
      ring_detect_pin_r <= ring_det;
    end
  end

  // Remembers a force on-hook until the line truly rests on-hook
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      forced_onhook_r <= 1'b0;
    end else if (force_onhook) begin
      forced_onhook_r <= 1'b1;
    end else if (!offhook_nxt) begin
      forced_onhook_r <= 1'b0;
    end
  end

  // Off-hook counter restarts only on a real on-hook to off-hook move
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_offhook_r  <= 1'b0;
      offhook_count_r <= OFFHOOK_CNT_RESET;
    end else begin
      line_offhook_r <= offhook_nxt;
      if (offhook_nxt && !line_offhook_r && !forced_onhook_r) begin
        offhook_count_r <= OFFHOOK_CNT_RESET;
      end else if (offhook_nxt && offhook_count_r != '1) begin
        offhook_count_r <= offhook_count_r + 1'b1;
      end
    end
  end

  // Read-only register port; no write path reaches the sense field
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r  <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd && reg_addr == LINE_SENSE_OFFSET) begin
        reg_rdata_r <= {line_sense_value_r, 3'b000};
      end else if (reg_rd) begin
        reg_rdata_r <= 8'h00;
      end
    end
  end

  a_sense_presence : assert property (@(posedge ref_clk) disable iff (rst)
    (!ctrl.mode && !ctrl.hook_off_request && ctrl.onhook_monitor_enable)
    |=> line_sense_value_r ==
        ($past(meas.line_voltage_present) ? 5'h1f : 5'h00))
    else $error("monitor presence code wrong");
  a_sense_current : assert property (@(posedge ref_clk) disable iff (rst)
    (!ctrl.mode && ctrl.hook_off_request)
    |=> line_sense_value_r == $past(meas.loop_current_code))
    else $error("loop current not reported off-hook");
  a_sense_voltage : assert property (@(posedge ref_clk) disable iff (rst)
    ctrl.mode |=> line_sense_value_r == $past(meas.line_voltage_code))
    else $error("line voltage not reported");
  a_sense_idle : assert property (@(posedge ref_clk) disable iff (rst)
    (ctrl == '0) |=> line_sense_value_r == 5'h00)
    else $error("idle sense not zero");
  a_force_hold : assert property (@(posedge ref_clk) disable iff (rst)
    (line_offhook_r && force_onhook) |=> !line_offhook_r ##0
    offhook_count_r == $past(offhook_count_r))
    else $error("force on-hook disturbed the counter");
  a_read_sense : assert property (@(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == LINE_SENSE_OFFSET) |=> reg_rvalid_r &&
    reg_rdata_r == {$past(line_sense_value_r), 3'b000})
    else $error("sense read data wrong");
  a_ring_stream : assert property (@(posedge ref_clk) disable iff (rst)
    (!ctrl.hook_off_request && !ctrl.onhook_monitor_enable) |=>
    serial_data_valid_r && serial_data_output_r == $past(rect))
    else $error("ring data missing on stream");
  a_ring_pin : assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ring_detect_pin_r == ($past(rect) >= RING_THRESHOLD))
    else $error("ring pin not following detector");

  c_ring_seen : cover property (@(posedge ref_clk) ring_detect_pin_r);
  c_force_on : cover property (@(posedge ref_clk)
    line_offhook_r ##1 force_onhook);
  c_overload : cover property (@(posedge ref_clk)
    line_offhook_r && line_sense_value_r == 5'h1f);

endmodule
`default_nettype wire

/* File: inc/drlm_pkg.sv */
// Package of constants and types for the ring detect and line monitor block
package drlm_pkg;

  localparam logic [7:0] LINE_SENSE_OFFSET   = 8'h13;
  localparam int         SENSE_LSB           = 3;
  localparam int         SENSE_W             = 5;
  localparam logic [4:0] SENSE_ALL_ONES      = 5'h1f;
  localparam logic [4:0] SENSE_ALL_ZEROS     = 5'h00;
  localparam logic [4:0] SENSE_RESET         = 5'h00;
  localparam logic [7:0] RING_THRESHOLD      = 8'h20;
  localparam int         OFFHOOK_CNT_W       = 8;
  localparam logic [7:0] OFFHOOK_CNT_RESET   = 8'h00;

  typedef enum logic [1:0] {
    DRLM_SRC_ZERO,
    DRLM_SRC_PRESENCE,
    DRLM_SRC_CURRENT,
    DRLM_SRC_VOLTAGE
  } drlm_sense_src_t;

  typedef enum logic [1:0] {
    DRLM_SDO_RING,
    DRLM_SDO_LINE,
    DRLM_SDO_NONE
  } drlm_sdo_src_t;

  // Host control bits of the line interface
  typedef struct packed {
    logic mode;
    logic hook_off_request;
    logic onhook_monitor_enable;
    logic ring_rectifier_full_wave;
    logic ring_squelch;
  } drlm_ctrl_t;

  // Analog front end measurements, already converted
  typedef struct packed {
    logic [4:0] line_voltage_code;
    logic [4:0] loop_current_code;
    logic       line_voltage_present;
    logic [7:0] line_sample;
  } drlm_meas_t;

endpackage

/* File: rtl/drlm_ring_rect.sv */
// Ring input rectifier with squelch and ring threshold detector
`timescale 1ns/1ps
`default_nettype none
module drlm_ring_rect
  import drlm_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [7:0] ring_sense_inputs,
  input  wire logic       full_wave,
  input  wire logic       squelch,
  output logic      [7:0] rect_r,
  output logic            ring_det_r
);

  logic [7:0] rect_nxt;

  // Signed differential ring sample; squelch forces the path to rest
  always_comb begin
    if (squelch) begin
      rect_nxt = 8'h00;
    end else if (!ring_sense_inputs[7]) begin
      rect_nxt = ring_sense_inputs;
    end else if (full_wave) begin
      rect_nxt = 8'(-ring_sense_inputs);
    end else begin
      rect_nxt = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rect_r     <= 8'h00;
      ring_det_r <= 1'b0;
    end else begin
      rect_r     <= rect_nxt;
      ring_det_r <= (rect_nxt >= RING_THRESHOLD);
    end
  end

  a_half_wave_neg : assert property (@(posedge ref_clk) disable iff (rst)
    (!full_wave && !squelch && ring_sense_inputs[7]) |=> rect_r == 8'h00)
    else $error("negative half cycle passed in half-wave mode");
  a_full_wave_abs : assert property (@(posedge ref_clk) disable iff (rst)
    (full_wave && !squelch && ring_sense_inputs[7]) |=>
    rect_r == 8'(-$past(ring_sense_inputs)))
    else $error("full-wave output is not the magnitude");

endmodule
`default_nettype wire

/* File: bench/drlm_host_model.sv */
// Host model: read strobe port and control bits of the line interface
`timescale 1ns/1ps
`default_nettype none
module drlm_host_model
  import drlm_pkg::*;
(
  input  wire logic ref_clk,
  output logic       reg_rd,
  output logic [7:0] reg_addr,
  output drlm_ctrl_t ctrl
);
  initial begin
    reg_rd   = 1'b0;
    reg_addr = 8'h00;
    ctrl     = '0;
  end
  // Control word applied once, just after a falling edge
  task automatic set_ctrl(input drlm_ctrl_t c);
    ctrl = c;
  endtask
  // Strobe held up to the taking edge, address scrambled afterwards
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask
  // Squelch set then cleared no sooner than 1 ms
  task automatic squelch_pulse(input int cyc);
    ctrl.ring_squelch = 1'b1;
    repeat (cyc) @(negedge ref_clk);
    ctrl.ring_squelch = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the ring detect and line monitor block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import drlm_pkg::*;
;
  logic       ref_clk, rst, reg_rd, rvalid, det, sval, offh;
  logic [7:0] reg_addr, rdata, ring, serial_data_output, cnt, c0, r, cp;
  logic       fprev, offprev;
  drlm_ctrl_t ctrl, cv;
  drlm_meas_t meas;
  int         n_fail, n_tests, cyc, i;
  logic [7:0] tbl [6] = '{8'h80, 8'he0, 8'he1, 8'h1f, 8'h20, 8'h7f};
  drlm_host_model host (.ref_clk(ref_clk), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .ctrl(ctrl));
  drlm_line_monitor dut (.ref_clk(ref_clk), .rst(rst), .ctrl(ctrl),
    .meas(meas), .ring_sense_inputs(ring), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata_r(rdata), .reg_rvalid_r(rvalid),
    .ring_detect_pin_r(det), .serial_data_output_r(serial_data_output),
    .serial_data_valid_r(sval), .line_offhook_r(offh),
    .offhook_count_r(cnt));
  function automatic logic [7:0] rect_m(logic [7:0] s, logic fw, logic sq);
    if (sq) return 8'h00;
    if (s[7]) return fw ? 8'h00 - s : 8'h00;
    return s;
  endfunction
  function automatic logic [4:0] sense_m(drlm_ctrl_t c, drlm_meas_t m);
    if (c.mode) return m.line_voltage_code;
    if (c.hook_off_request) return m.loop_current_code;
    if (c.onhook_monitor_enable) return m.line_voltage_present ? 5'h1f : 5'h00;
    return 5'h00;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Checks ring pin and stream against the model for the held inputs
  task automatic chk_ring();
    r = rect_m(ring, ctrl.ring_rectifier_full_wave, ctrl.ring_squelch);
    `CHK(det, r >= RING_THRESHOLD)
    if (!ctrl.hook_off_request && !ctrl.onhook_monitor_enable) begin
      `CHK(serial_data_output, r)
      `CHK(sval, 1'b1)
    end else if (ctrl.mode && ctrl.hook_off_request &&
                 !ctrl.onhook_monitor_enable) begin
      `CHK(sval, 1'b0)
    end else begin
      `CHK(serial_data_output, meas.line_sample)
      `CHK(sval, 1'b1)
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    meas = '0;
    ring = 8'h00;
    fprev = 1'b0;
    offprev = 1'b0;
    cp = 8'h00;
    void'($urandom(32'hc478));
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    for (i = 0; i < 80; i++) begin
      @(negedge ref_clk);
      cv = drlm_ctrl_t'($urandom & 32'h1e);
      if (i < 12) begin
        cv.ring_rectifier_full_wave = (i >= 6);
      end
      host.set_ctrl(cv);
      meas = drlm_meas_t'($urandom);
      ring = (i < 12) ? tbl[i % 6] : 8'($urandom);
      repeat (3) @(negedge ref_clk);
      chk_ring();
      `CHK(offh, ctrl.hook_off_request & !ctrl.mode)
      if (offh && fprev) begin
        `CHK(cnt, (cp > 8'hfc) ? 8'hff : cp + 8'h03)
      end else if (offh && !offprev) begin
        `CHK(cnt, 8'h02)
      end
      c0 = cnt;
      host.rd(LINE_SENSE_OFFSET);
      `CHK(rvalid, 1'b1)
      `CHK(rdata, {sense_m(ctrl, meas), 3'b000})
      host.rd(LINE_SENSE_OFFSET + 8'h01);
      `CHK(rdata, 8'h00)
      if (ctrl.mode && ctrl.hook_off_request) `CHK(cnt, c0)
      if (offh) `CHK(cnt != 8'h00, 1'b1)
      fprev = ctrl.mode && ctrl.hook_off_request;
      offprev = offh;
      cp = cnt;
    end
    @(negedge ref_clk);
    cv = '0;
    cv.ring_rectifier_full_wave = 1'b1;
    host.set_ctrl(cv);
    ring = 8'h80;
    repeat (3) @(negedge ref_clk);
    chk_ring();
    fork
      host.squelch_pulse(20000);
      begin
        repeat (4) @(negedge ref_clk);
        chk_ring();
        `CHK(det, 1'b0)
      end
    join
    repeat (3) @(negedge ref_clk);
    chk_ring();
    report_and_stop();
  end
endmodule
`default_nettype wire
